// >>> core/tpx_exchanger.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - three 18-bit two-way ports, each storing words
// - any port's data reaches other ports
// - latch open: storage follows port input
// - latch closed, steady clock, no software capture write: storage holds
// - latch closed: clock rise captures input
// - all three storages alike, own controls
// - drive_n low drives port, high floats
// - port1 drives port2 or port3 storage
// - port2 pick low drives port3 storage
// - port3 drives port1 or port2 storage
`include "tpx_consts.svh"

// small log buffer between capture events and software
module tpx_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 4
)
(
    // clocking
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;

    // honest full and empty from the fill count
    assign in_ready = cnt_reg != (AW+1)'(DEPTH);
    assign out_valid = cnt_reg != '0;
    assign out_data = mem[rd_reg];
    assign push = in_valid & in_ready & ce;
    assign pop = out_valid & out_ready & ce;

    // storage words
    always_ff @(posedge aclk)
    begin
        if (push)
        begin
            mem[wr_reg] <= in_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (pop)
            begin
                rd_reg <= rd_reg + 1'b1;
            end
            if (push && !pop)
            begin
                cnt_reg <= cnt_reg + 1'b1;
            end
            else if (pop && !push)
            begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end
endmodule : tpx_fifo

module tpx_exchanger
(
    // clock, reset, freeze
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // register bus write
    input wire logic [`TPX_AXI_AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // register bus read
    input wire logic [`TPX_AXI_AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // port 1 pins
    input wire tpx_pkg::tpx_word_type port1_data_in,
    output tpx_pkg::tpx_word_type port1_data_out,
    output logic port1_data_oe,
    input wire logic port1_latch_open,
    input wire logic port1_capture_edge,
    input wire logic port1_drive_n,
    input wire logic port1_source_pick,
    // port 2 pins
    input wire tpx_pkg::tpx_word_type port2_data_in,
    output tpx_pkg::tpx_word_type port2_data_out,
    output logic port2_data_oe,
    input wire logic port2_latch_open,
    input wire logic port2_capture_edge,
    input wire logic port2_drive_n,
    input wire logic port2_source_pick,
    // port 3 pins
    input wire tpx_pkg::tpx_word_type port3_data_in,
    output tpx_pkg::tpx_word_type port3_data_out,
    output logic port3_data_oe,
    input wire logic port3_latch_open,
    input wire logic port3_capture_edge,
    input wire logic port3_drive_n,
    input wire logic port3_source_pick,
    // capture log room
    output logic log_in_ready
);
    import tpx_pkg::*;

    tpx_word_type [2:0] din_m_reg;
    tpx_word_type [2:0] din_s_reg;
    tpx_word_type [2:0] held_reg;
    tpx_word_type [2:0] out_reg;
    logic [2:0] le_m_reg, le_s_reg, ck_m_reg, ck_s_reg, ck_d_reg;
    logic [2:0] dn_m_reg, dn_s_reg, pk_m_reg, pk_s_reg;
    logic [2:0] oe_reg;
    logic [2:0] sw_cap_reg;
    logic [2:0] cap_fire;
    tpx_log_type log_in;
    tpx_log_type log_out;
    logic log_valid;
    logic log_pop;
    logic aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg;
    logic [`TPX_AXI_AW-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic wstrb0_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rd_data;
    logic [1:0] rd_resp;
    logic do_wr, ar_fire;

    // which storage a port drives: never its own
    function automatic logic [1:0] tpx_src(input logic [1:0] p, input logic pick);
        case (p)
            2'h0: tpx_src = pick ? 2'h2 : 2'h1;
            2'h1: tpx_src = pick ? 2'h0 : 2'h2;
            default: tpx_src = pick ? 2'h1 : 2'h0;
        endcase
    endfunction : tpx_src

    // pins pass two flip-flops before use
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            din_m_reg <= '0;
            din_s_reg <= '0;
            le_m_reg <= '0;
            le_s_reg <= '0;
            ck_m_reg <= '0;
            ck_s_reg <= '0;
            ck_d_reg <= '0;
            dn_m_reg <= `TPX_RST_DRIVE_N;
            dn_s_reg <= `TPX_RST_DRIVE_N;
            pk_m_reg <= '0;
            pk_s_reg <= '0;
        end
        else if (ce)
        begin
            din_m_reg <= {port3_data_in, port2_data_in, port1_data_in};
            din_s_reg <= din_m_reg;
            le_m_reg <= {port3_latch_open, port2_latch_open, port1_latch_open};
            le_s_reg <= le_m_reg;
            ck_m_reg <= {port3_capture_edge, port2_capture_edge, port1_capture_edge};
            ck_s_reg <= ck_m_reg;
            ck_d_reg <= ck_s_reg;
            dn_m_reg <= {port3_drive_n, port2_drive_n, port1_drive_n};
            dn_s_reg <= dn_m_reg;
            pk_m_reg <= {port3_source_pick, port2_source_pick, port1_source_pick};
            pk_s_reg <= pk_m_reg;
        end
    end

    // rising clock edge or software capture pulse
    assign cap_fire = (ck_s_reg & ~ck_d_reg) | sw_cap_reg;

    // storage: open latch follows, closed latch holds or captures
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            held_reg <= {3{`TPX_RST_WORD}};
        end
        else if (ce)
        begin
            for (int i = 0; i < `TPX_PORTS; i++)
            begin
                if (le_s_reg[i])
                begin
                    held_reg[i] <= din_s_reg[i];
                end
                else if (cap_fire[i])
                begin
                    held_reg[i] <= din_s_reg[i];
                end
            end
        end
    end

    // output selectors and drivers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            out_reg <= {3{`TPX_RST_WORD}};
            oe_reg <= '0;
        end
        else if (ce)
        begin
            for (int i = 0; i < `TPX_PORTS; i++)
            begin
                out_reg[i] <= held_reg[tpx_src(2'(i), pk_s_reg[i])];
            end
            oe_reg <= ~dn_s_reg;
        end
    end

    assign port1_data_out = out_reg[0];
    assign port2_data_out = out_reg[1];
    assign port3_data_out = out_reg[2];
    assign port1_data_oe = oe_reg[0];
    assign port2_data_oe = oe_reg[1];
    assign port3_data_oe = oe_reg[2];

    // log the lowest-numbered port captured this cycle
    always_comb
    begin
        log_in.port = cap_fire[0] ? 2'h0 : (cap_fire[1] ? 2'h1 : 2'h2);
        log_in.data = din_s_reg[log_in.port];
    end

    tpx_fifo #(
        .WIDTH($bits(tpx_log_type)),
        .DEPTH(`TPX_LOG_DEPTH)
    ) u_log (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .in_valid(|cap_fire),
        .in_ready(log_in_ready),
        .in_data(log_in),
        .out_valid(log_valid),
        .out_ready(log_pop),
        .out_data(log_out)
    );

    // write channels are taken in either order, answered once both held
    assign awready = !aw_hold_reg && !bvalid_reg;
    assign wready = !w_hold_reg && !bvalid_reg;
    assign do_wr = aw_hold_reg && w_hold_reg && !bvalid_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `TPX_RESP_OKAY;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb0_reg <= 1'b0;
            sw_cap_reg <= '0;
        end
        else if (ce)
        begin
            sw_cap_reg <= '0;
            if (awvalid && awready)
            begin
                aw_hold_reg <= 1'b1;
                awaddr_reg <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_hold_reg <= 1'b1;
                wdata_reg <= wdata;
                wstrb0_reg <= wstrb[0];
            end
            if (do_wr)
            begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                if ({awaddr_reg[7:2], 2'h0} == `TPX_OFF_CAPTURE)
                begin
                    bresp_reg <= `TPX_RESP_OKAY;
                    sw_cap_reg <= wstrb0_reg ? wdata_reg[2:0] : 3'h0;
                end
                else
                begin
                    bresp_reg <= `TPX_RESP_SLVERR;
                end
            end
            else if (bvalid_reg && bready)
            begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // read decode
    always_comb
    begin
        rd_data = '0;
        rd_resp = `TPX_RESP_OKAY;
        case ({araddr[7:2], 2'h0})
            `TPX_OFF_CAPTURE: rd_data = '0;
            `TPX_OFF_HELD1: rd_data = {14'h0000, held_reg[0]};
            `TPX_OFF_HELD2: rd_data = {14'h0000, held_reg[1]};
            `TPX_OFF_HELD3: rd_data = {14'h0000, held_reg[2]};
            `TPX_OFF_PINS: rd_data = {20'h00000, pk_s_reg, dn_s_reg, ck_s_reg, le_s_reg};
            `TPX_OFF_LOG: rd_data = {log_valid, 11'h000, log_out};
            default: rd_resp = `TPX_RESP_DECERR;
        endcase
    end

    assign arready = !rvalid_reg;
    assign ar_fire = arvalid && arready;
    assign log_pop = ar_fire && ({araddr[7:2], 2'h0} == `TPX_OFF_LOG); // read pops
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= `TPX_RESP_OKAY;
        end
        else if (ce)
        begin
            if (ar_fire)
            begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_data;
                rresp_reg <= rd_resp;
            end
            else if (rready)
            begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // checks on storage and drivers
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_transparent;
        ce && le_s_reg[0] |=> held_reg[0] == $past(din_s_reg[0]);
    endproperty
    a_transparent: assert property (p_transparent) else $error("open latch not following");

    property p_hold;
        ce && !le_s_reg[1] && !cap_fire[1] |=> $stable(held_reg[1]);
    endproperty
    a_hold: assert property (p_hold) else $error("closed latch changed");

    property p_capture;
        ce && !le_s_reg[1] && ck_s_reg[1] && !ck_d_reg[1] |=> held_reg[1] == $past(din_s_reg[1]);
    endproperty
    a_capture: assert property (p_capture) else $error("clock rise not captured");

    property p_third_alike;
        ce && !le_s_reg[2] && $rose(ck_s_reg[2]) |=> held_reg[2] == $past(din_s_reg[2]);
    endproperty
    a_third_alike: assert property (p_third_alike) else $error("port3 storage differs");

    property p_float;
        ce ##0 dn_s_reg[2] |=> !port3_data_oe;
    endproperty
    a_float: assert property (p_float) else $error("disabled port driven");

    property p_port1_pick;
        ce && !dn_s_reg[0] |=> port1_data_oe && port1_data_out == ($past(pk_s_reg[0]) ?
            $past(held_reg[2]) : $past(held_reg[1]));
    endproperty
    a_port1_pick: assert property (p_port1_pick) else $error("port1 source wrong");

    property p_port2_low;
        ce && !pk_s_reg[1] |=> port2_data_out == $past(held_reg[2]);
    endproperty
    a_port2_low: assert property (p_port2_low) else $error("port2 low source wrong");

    property p_port3_pick;
        ce && !dn_s_reg[2] |=> port3_data_oe && port3_data_out == ($past(pk_s_reg[2]) ?
            $past(held_reg[1]) : $past(held_reg[0]));
    endproperty
    a_port3_pick: assert property (p_port3_pick) else $error("port3 source wrong");

    property p_port2_high;
        ce && pk_s_reg[1] |=> port2_data_out == $past(held_reg[0]);
    endproperty
    a_port2_high: assert property (p_port2_high) else $error("port2 high source wrong");

    c_capture: cover property (ce && !le_s_reg[0] && cap_fire[0]);
    c_transparent_run: cover property (le_s_reg[1] [*3]);
    c_port3_from_2: cover property (port3_data_oe && pk_s_reg[2]);
    c_log_full: cover property (!log_in_ready);
endmodule : tpx_exchanger
`default_nettype wire

// >>> pkg/tpx_consts.svh
`ifndef TPX_CONSTS_SVH
`define TPX_CONSTS_SVH
// port geometry
`define TPX_W 18
`define TPX_PORTS 3
`define TPX_LOG_DEPTH 4
// register bus
`define TPX_AXI_AW 8
`define TPX_OFF_CAPTURE 8'h00
`define TPX_OFF_HELD1 8'h04
`define TPX_OFF_HELD2 8'h08
`define TPX_OFF_HELD3 8'h0C
`define TPX_OFF_PINS 8'h10
`define TPX_OFF_LOG 8'h14
// reset values
`define TPX_RST_WORD 18'h00000
`define TPX_RST_DRIVE_N 3'h7
// answer codes
`define TPX_RESP_OKAY 2'h0
`define TPX_RESP_SLVERR 2'h2
`define TPX_RESP_DECERR 2'h3
`endif

// >>> pkg/tpx_pkg.sv
`include "tpx_consts.svh"
package tpx_pkg;
    // one port's word
    typedef logic [`TPX_W-1:0] tpx_word_type;
    // capture log entry: port index 0..2 and captured word
    typedef struct packed
    {
        logic [1:0] port;
        tpx_word_type data;
    } tpx_log_type;
endpackage : tpx_pkg

// >>> verif/tpx_bus_partner.sv
`timescale 1ns/100ps
`default_nettype none
// outside logic on the three 18-bit buses
module tpx_bus_partner
(
    // device side of each bus
    input wire logic [2:0] dev_oe,
    input wire tpx_pkg::tpx_word_type [2:0] dev_out,
    // word the outside logic offers
    input wire tpx_pkg::tpx_word_type [2:0] ext_word,
    // resolved bus levels
    output tpx_pkg::tpx_word_type [2:0] bus
);
    import tpx_pkg::*;
    // outside logic backs off while the device drives, so no contention
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            bus[i] = dev_oe[i] ? dev_out[i] : ext_word[i];
        end
    end
endmodule : tpx_bus_partner
`default_nettype wire

// >>> verif/tpx_exchanger_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "tpx_consts.svh"
module tpx_exchanger_test;
    import tpx_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [2:0] lat = 3'h0;
    logic [2:0] edg = 3'h0;
    logic [2:0] drv_n = 3'h7;
    logic [2:0] pick = 3'h0;
    logic ce = 1'b1;
    wire [2:0] oe;
    tpx_word_type [2:0] ext = '0;
    tpx_word_type [2:0] bus;
    wire tpx_word_type [2:0] dout;
    wire awready, wready, bvalid, arready, rvalid, log_in_ready;
    wire [1:0] bresp;
    wire [1:0] rresp;
    wire [31:0] rdata;
    int fail_count = 0;
    int n_compared = 0;
    int cyc = 0;
    logic [31:0] rd;
    logic [1:0] rs;
    tpx_word_type vals [3] = '{18'h2A5A5, 18'h15A5A, 18'h3C3C3};
    // rows: port, pick, storage expected on that port
    int rp [6] = '{0, 0, 1, 1, 2, 2};
    logic rk [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    int rsrc [6] = '{1, 2, 2, 0, 0, 1};

    // free running clock
    always #10 aclk = ~aclk;

    tpx_exchanger u_tpx_exchanger (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready),
        .port1_data_in(bus[0]), .port1_data_out(dout[0]), .port1_data_oe(oe[0]),
        .port1_latch_open(lat[0]), .port1_capture_edge(edg[0]), .port1_drive_n(drv_n[0]),
        .port1_source_pick(pick[0]),
        .port2_data_in(bus[1]), .port2_data_out(dout[1]), .port2_data_oe(oe[1]),
        .port2_latch_open(lat[1]), .port2_capture_edge(edg[1]), .port2_drive_n(drv_n[1]),
        .port2_source_pick(pick[1]),
        .port3_data_in(bus[2]), .port3_data_out(dout[2]), .port3_data_oe(oe[2]),
        .port3_latch_open(lat[2]), .port3_capture_edge(edg[2]), .port3_drive_n(drv_n[2]),
        .port3_source_pick(pick[2]), .log_in_ready(log_in_ready));

    tpx_bus_partner u_tpx_bus_partner (.dev_oe(oe), .dev_out(dout), .ext_word(ext), .bus(bus));

    // verdict and end of run
    task automatic conclude();
        if (fail_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude

    // one comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask : tick

    // bus write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit ta = 1'b0;
        bit tw = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (!ta && awready)
            begin
                ta = 1'b1;
                awvalid <= 1'b0;
            end
            if (!tw && wready)
            begin
                tw = 1'b1;
                wvalid <= 1'b0;
            end
            if (bvalid)
            begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask : wr

    // bus read
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit ta = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (!ta && arready)
            begin
                ta = 1'b1;
                arvalid <= 1'b0;
            end
            if (rvalid)
            begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask : rd_reg

    // stored word of port i as software sees it
    task automatic held(input int i, input tpx_word_type v);
        rd_reg(`TPX_OFF_HELD1 + 8'(4 * i), rd, rs);
        chk({14'h0, rd[17:0]}, {14'h0, v});
    endtask : held

    // clocked capture with the latch closed
    task automatic cap(input int i, input tpx_word_type v);
        ext[i] <= v;
        tick(4);
        edg[i] <= 1'b1;
        tick(4);
        edg[i] <= 1'b0;
        tick(4);
    endtask : cap

    // hang guard
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            fail_count++;
            conclude();
        end
    end

    // main sequence
    initial
    begin
        tick(10);
        aresetn <= 1'b1;
        tick(2);
        chk({29'h0, oe}, 32'h0);
        for (int i = 0; i < 3; i++)
            cap(i, vals[i]);
        for (int i = 0; i < 3; i++)
            held(i, vals[i]);
        ext[0] <= 18'h00FFF;
        tick(8);
        held(0, vals[0]);
        for (int r = 0; r < 6; r++)
        begin
            drv_n[rp[r]] <= 1'b0;
            pick[rp[r]] <= rk[r];
            tick(6);
            chk({29'h0, oe}, 32'h1 << rp[r]);
            chk({14'h0, dout[rp[r]]}, {14'h0, vals[rsrc[r]]});
            drv_n <= 3'h7;
            pick[rp[r]] <= ~rk[r];
            tick(6);
            chk({29'h0, oe}, 32'h0);
        end
        // transparent mode with the clock moving, then live data to port 3
        lat[1] <= 1'b1;
        ext[1] <= 18'h0BEEF;
        edg[1] <= 1'b1;
        tick(6);
        held(1, 18'h0BEEF);
        ext[1] <= 18'h12345;
        edg[1] <= 1'b0;
        drv_n[2] <= 1'b0;
        pick[2] <= 1'b1;
        tick(6);
        chk({14'h0, dout[2]}, 32'h12345);
        drv_n <= 3'h7;
        lat[1] <= 1'b0;
        tick(6);
        ext[1] <= 18'h00001;
        tick(6);
        held(1, 18'h12345);
        // empty the log, fill it until it refuses, drain it
        for (int k = 0; k < 8; k++)
        begin
            rd_reg(`TPX_OFF_LOG, rd, rs);
            if (rd[31] !== 1'b1)
                break;
        end
        chk({31'h0, log_in_ready}, 32'h1);
        for (int k = 0; k < 5; k++)
        begin
            wr(`TPX_OFF_CAPTURE, 32'h1, rs);
            chk({30'h0, rs}, {30'h0, `TPX_RESP_OKAY});
        end
        tick(2);
        chk({31'h0, log_in_ready}, 32'h0);
        for (int k = 0; k < 4; k++)
        begin
            rd_reg(`TPX_OFF_LOG, rd, rs);
            chk(rd, 32'h80000FFF);
        end
        rd_reg(`TPX_OFF_LOG, rd, rs);
        chk({31'h0, rd[31]}, 32'h0);
        chk({31'h0, log_in_ready}, 32'h1);
        // refused accesses
        wr(`TPX_OFF_HELD1, 32'h0, rs);
        chk({30'h0, rs}, {30'h0, `TPX_RESP_SLVERR});
        rd_reg(8'h20, rd, rs);
        chk({30'h0, rs}, {30'h0, `TPX_RESP_DECERR});
        chk(rd, 32'h0);
        // software capture on port 3, then the synchronised control levels
        ext[2] <= 18'h2468A;
        pick <= 3'h5;
        tick(4);
        wr(`TPX_OFF_CAPTURE, 32'h4, rs);
        chk({30'h0, rs}, {30'h0, `TPX_RESP_OKAY});
        held(2, 18'h2468A);
        rd_reg(`TPX_OFF_PINS, rd, rs);
        chk(rd, 32'h00000BC0);
        // freeze: nothing moves while ce is low, then the open latch follows
        ce <= 1'b0;
        lat[0] <= 1'b1;
        ext[0] <= 18'h11111;
        drv_n[1] <= 1'b0;
        tick(6);
        chk({29'h0, oe}, 32'h0);
        ce <= 1'b1;
        tick(6);
        chk({29'h0, oe}, 32'h2);
        chk({14'h0, dout[1]}, 32'h2468A);
        held(0, 18'h11111);
        lat[0] <= 1'b0;
        drv_n <= 3'h7;
        tick(2);
        // second reset while a port drives
        drv_n[0] <= 1'b0;
        tick(6);
        aresetn <= 1'b0;
        drv_n[0] <= 1'b1;
        tick(3);
        chk({29'h0, oe}, 32'h0);
        aresetn <= 1'b1;
        tick(1);
        held(0, `TPX_RST_WORD);
        conclude();
    end
endmodule : tpx_exchanger_test
`default_nettype wire
